// [rtl/pmic_gpio_rail_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module pmic_gpio_rail_sequencer #(
  parameter logic [1:0] CONFIG_IMAGE = rail_seq_pkg::IMG_FIRST,
  parameter int unsigned RESET_DELAY_US = rail_seq_pkg::RESET_DELAY_US,
  parameter int unsigned TICK_CYCLES = rail_seq_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic io_line_two,
  input wire logic io_line_four,
  input wire logic io_line_five_in,
  input wire logic io_line_seven_in,
  output logic io_line_five_out,
  output logic io_line_five_oe,
  output logic io_line_seven_out,
  output logic io_line_seven_oe,
  input wire logic i2c_write_valid,
  input wire logic [7:0] i2c_addr_byte,
  input wire logic [3:0] i2c_sleep_bits,
  input wire logic rails_good_in,
  input wire logic event_in,
  input wire logic event_clear,
  input wire logic uvlo_ok,
  output rail_seq_pkg::rails_s rail_enable,
  output rail_seq_pkg::setpoints_s setpoints,
  output rail_seq_pkg::sleep_ctl_s sleep_ctl,
  output logic deep_sleep_req
);
  localparam int unsigned W = rail_seq_pkg::DLY_W;
  localparam int unsigned RW = 16;
  wire img1 = (CONFIG_IMAGE == rail_seq_pkg::IMG_FIRST);

  // Three-stage synchronisers; a change counts once stages two and three agree
  logic [2:0] s2, s4, s5, s7;
  logic io2, io4, io5, io7;
  always_ff @(posedge clk) begin
    s2 <= {s2[1:0], io_line_two};
    s4 <= {s4[1:0], io_line_four};
    s5 <= {s5[1:0], io_line_five_in};
    s7 <= {s7[1:0], io_line_seven_in};
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      io2 <= 1'b0;
      io4 <= 1'b0;
      io5 <= 1'b0;
      io7 <= 1'b0;
    end else begin
      if (s2[1] == s2[2]) io2 <= s2[2];
      if (s4[1] == s4[2]) io4 <= s4[2];
      if (s5[1] == s5[2]) io5 <= s5[2];
      if (s7[1] == s7[2]) io7 <= s7[2];
    end
  end

  // Microsecond tick: TICK_CYCLES clocks per microsecond, at most 64
  logic [5:0] div;
  logic tick;
  always_ff @(posedge clk) begin
    if (!resetn || div == 6'(TICK_CYCLES - 1)) begin
      div <= 6'h00;
    end else begin
      div <= div + 6'h01;
    end
  end
  always_ff @(posedge clk) begin
    tick <= resetn && (div == 6'(TICK_CYCLES - 1));
  end

  // I2C address match; only a write byte carries register updates
  wire addr_hit = i2c_write_valid && (i2c_addr_byte == rail_seq_pkg::I2C_WRITE_BYTE);
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sleep_ctl <= '0;
    end else if (addr_hit) begin
      sleep_ctl <= rail_seq_pkg::sleep_ctl_s'(i2c_sleep_bits);
    end
  end

  // Deep sleep: pin or I2C bit in image one, I2C bit only in image two
  always_ff @(posedge clk) begin
    if (!resetn) begin
      deep_sleep_req <= 1'b0;
    end else if (img1) begin
      deep_sleep_req <= io5 || sleep_ctl.deep_sleep_en;
    end else begin
      deep_sleep_req <= sleep_ctl.deep_sleep_en;
    end
  end

  // Image two sequencing: each stage waits on its predecessor with its delay; lr2 and sd2 both wait on sd3
  wire ext_good = !img1 && io4;
  rail_seq_pkg::rails_s on_done, off_done, next_rail;
  rail_seq_pkg::rails_s trig_on;
  assign trig_on.step_down_one = ext_good;
  assign trig_on.linear_reg_one = ext_good && rail_enable.step_down_one;
  assign trig_on.step_down_three = ext_good && rail_enable.linear_reg_one;
  assign trig_on.linear_reg_two = ext_good && rail_enable.step_down_three;
  assign trig_on.step_down_two = ext_good && rail_enable.step_down_three;
  localparam logic [4:0][W-1:0] ON_LIM = {W'(rail_seq_pkg::EXT_GOOD_DELAY_US),
    W'(rail_seq_pkg::CHAIN_DELAY_US), W'(rail_seq_pkg::CHAIN_DELAY_US),
    W'(rail_seq_pkg::CHAIN_DELAY_US), W'(rail_seq_pkg::LAST_DELAY_US)};
  localparam logic [4:0][W-1:0] OFF_LIM = {W'(rail_seq_pkg::OFF_DELAY_US),
    W'(rail_seq_pkg::OFF_DELAY_US), W'(rail_seq_pkg::OFF_DELAY_US),
    W'(rail_seq_pkg::LR2_OFF_DELAY_US), W'(rail_seq_pkg::OFF_DELAY_US)};
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_rail
      us_delay #(.W(W)) u_on (.clk(clk), .resetn(resetn), .tick(tick),
        .trigger(trig_on[g]), .limit(ON_LIM[g]), .done(on_done[g]));
      us_delay #(.W(W)) u_off (.clk(clk), .resetn(resetn), .tick(tick),
        .trigger(!ext_good && rail_enable[g]), .limit(OFF_LIM[g]), .done(off_done[g]));
      // Off when the delay expires; a zero delay still costs the first cycle
      assign next_rail[g] = img1 ? uvlo_ok : (on_done[g] || (rail_enable[g] && !off_done[g]));
    end
  endgenerate
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rail_enable <= '0;
    end else begin
      rail_enable <= next_rail;
    end
  end

  // Latches for the held selects, captured while the rail is off
  logic sel_sd1, sel_sd3;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sel_sd1 <= 1'b0;
      sel_sd3 <= 1'b0;
    end else begin
      if (!rail_enable.step_down_one) sel_sd1 <= io7;
      if (!rail_enable.step_down_three) sel_sd3 <= img1 ? io4 : io2;
    end
  end

  // Setpoint selection per image
  rail_seq_pkg::setpoints_s next_sp;
  assign next_sp.step_down_two_mv = !img1 ? rail_seq_pkg::IMG2_SD2_MV :
    (io2 ? rail_seq_pkg::IMG1_SD2_PRI_MV : rail_seq_pkg::IMG1_SD2_ALT_MV);
  assign next_sp.step_down_one_mv = !img1 ? rail_seq_pkg::IMG2_SD1_MV :
    (sel_sd1 ? rail_seq_pkg::IMG1_SD1_PRI_MV : rail_seq_pkg::IMG1_SD1_ALT_MV);
  assign next_sp.step_down_three_mv = img1 ?
    (sel_sd3 ? rail_seq_pkg::IMG1_SD3_PRI_MV : rail_seq_pkg::IMG1_SD3_ALT_MV) :
    (sel_sd3 ? rail_seq_pkg::IMG2_SD3_ALT_MV : rail_seq_pkg::IMG2_SD3_PRI_MV);
  always_ff @(posedge clk) begin
    if (!resetn) begin
      setpoints <= '0;
    end else begin
      setpoints <= next_sp;
    end
  end

  // Pending event; set wins over clear
  logic pending;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pending <= 1'b0;
    end else begin
      pending <= event_in || (pending && !event_clear);
    end
  end

  // Reset release counter, restarts if step_down_two good drops
  logic [RW-1:0] rst_count;
  wire sd2_good = !img1 && rail_enable.step_down_two && rails_good_in;
  wire rst_done = (rst_count >= RW'(RESET_DELAY_US));
  always_ff @(posedge clk) begin
    if (!resetn || !sd2_good) begin
      rst_count <= '0;
    end else if (tick && !rst_done) begin
      rst_count <= rst_count + RW'(1);
    end
  end

  // Open-drain pins: drive low only, float otherwise
  always_ff @(posedge clk) begin
    if (!resetn) begin
      io_line_five_oe <= 1'b0;
      io_line_seven_oe <= 1'b0;
    end else begin
      io_line_five_oe <= !img1 && pending;
      io_line_seven_oe <= !img1 && !(sd2_good && rst_done);
    end
  end
  always_ff @(posedge clk) begin
    io_line_five_out <= 1'b0;
    io_line_seven_out <= 1'b0;
  end
endmodule
`default_nettype wire

// [rtl/rail_seq_pkg.sv]
package rail_seq_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned US_PER_S = 1_000_000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / US_PER_S;
  localparam logic [6:0] I2C_ADDR7 = 7'h25;
  localparam logic [7:0] I2C_WRITE_BYTE = {I2C_ADDR7, 1'b0};
  localparam logic [7:0] I2C_READ_BYTE = {I2C_ADDR7, 1'b1};
  // Delays in microseconds
  localparam int unsigned EXT_GOOD_DELAY_US = 1000;
  localparam int unsigned CHAIN_DELAY_US = 1000;
  localparam int unsigned LAST_DELAY_US = 2000;
  localparam int unsigned OFF_DELAY_US = 1000;
  localparam int unsigned LR2_OFF_DELAY_US = 0;
  localparam int unsigned RESET_DELAY_US = 20000;
  localparam int unsigned DLY_W = 15;
  // Setpoints in millivolts
  localparam logic [11:0] IMG1_SD2_PRI_MV = 12'h384;
  localparam logic [11:0] IMG1_SD2_ALT_MV = 12'h2EE;
  localparam logic [11:0] IMG1_SD1_PRI_MV = 12'hB54;
  localparam logic [11:0] IMG1_SD1_ALT_MV = 12'h9C4;
  localparam logic [11:0] IMG1_SD3_PRI_MV = 12'h708;
  localparam logic [11:0] IMG1_SD3_ALT_MV = 12'h4B0;
  localparam logic [11:0] IMG2_SD3_PRI_MV = 12'h708;
  localparam logic [11:0] IMG2_SD3_ALT_MV = 12'h5DC;
  localparam logic [11:0] IMG2_SD1_MV = 12'hCE4;
  localparam logic [11:0] IMG2_SD2_MV = 12'h4B0;
  localparam logic [1:0] IMG_FIRST = 2'h1;
  localparam logic [1:0] IMG_SECOND = 2'h2;
  localparam int unsigned NRAILS = 5;
  // Rail enable order in image two: sd1, lr1, sd3, lr2, sd2
  typedef struct packed {
    logic step_down_one;
    logic linear_reg_one;
    logic step_down_three;
    logic linear_reg_two;
    logic step_down_two;
  } rails_s;
  typedef struct packed {
    logic [11:0] step_down_one_mv;
    logic [11:0] step_down_two_mv;
    logic [11:0] step_down_three_mv;
  } setpoints_s;
  typedef struct packed {
    logic sleep_en;
    logic sleep_variant_bit;
    logic deep_sleep_en;
    logic deep_sleep_variant_bit;
  } sleep_ctl_s;
endpackage

// [rtl/us_delay.sv]
`timescale 1ns/1ps
`default_nettype none
// Counts microsecond ticks while trigger holds; done stays high once reached, until trigger drops
module us_delay #(
  parameter int unsigned W = 15
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic tick,
  input wire logic trigger,
  input wire logic [W-1:0] limit,
  output logic done
);
  logic [W-1:0] count;
  wire reached = (count >= limit);
  // Restart whenever trigger drops so a glitchy input never shortens a delay
  always_ff @(posedge clk) begin
    if (!resetn || !trigger) begin
      count <= '0;
    end else if (tick && !reached) begin
      count <= count + W'(1);
    end
  end
  assign done = trigger && reached;
endmodule
`default_nettype wire

// [verif/gpio_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Board side of the open-drain pins: a released line reads high by its pull-up
module gpio_host_model (
  input wire logic io_line_five_oe,
  input wire logic io_line_seven_oe,
  output logic io_line_five_in,
  output logic io_line_seven_in
);
  assign io_line_five_in = !io_line_five_oe;
  assign io_line_seven_in = !io_line_seven_oe;
endmodule
`default_nettype wire

// [verif/pmic_gpio_rail_sequencer_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module pmic_gpio_rail_sequencer_tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic two = 1'b1;
  logic four = 1'b0;
  logic ev = 1'b0;
  logic evc = 1'b0;
  logic wv = 1'b0;
  logic good = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [3:0] bits = 4'h0;
  logic five_out, five_oe, seven_out, seven_oe, five_in, seven_in, dsr;
  rail_seq_pkg::rails_s rails;
  rail_seq_pkg::setpoints_s sp;
  rail_seq_pkg::sleep_ctl_s sc;
  int failures = 0;
  int n_checks = 0;
  localparam logic [11:0] SD3_ALT = rail_seq_pkg::IMG2_SD3_ALT_MV;
  localparam int TK = 2;
  localparam int RST_US = 20;
  // Second image only; a fast tick and short reset delay let the whole chain fit the run
  pmic_gpio_rail_sequencer #(.CONFIG_IMAGE(rail_seq_pkg::IMG_SECOND), .RESET_DELAY_US(RST_US),
    .TICK_CYCLES(TK)) dut (
    .clk(clk), .resetn(resetn), .io_line_two(two), .io_line_four(four), .io_line_five_in(five_in),
    .io_line_seven_in(seven_in), .io_line_five_out(five_out), .io_line_five_oe(five_oe),
    .io_line_seven_out(seven_out), .io_line_seven_oe(seven_oe), .i2c_write_valid(wv), .i2c_addr_byte(addr),
    .i2c_sleep_bits(bits), .rails_good_in(good), .event_in(ev), .event_clear(evc), .uvlo_ok(1'b0),
    .rail_enable(rails), .setpoints(sp), .sleep_ctl(sc), .deep_sleep_req(dsr));
  gpio_host_model host (.io_line_five_oe(five_oe), .io_line_seven_oe(seven_oe), .io_line_five_in(five_in),
    .io_line_seven_in(seven_in));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic check_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic check_vec(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  // One decoded write, visible one cycle after it is taken
  task automatic wr(input logic [7:0] a, input logic [3:0] b);
    @(negedge clk);
    wv = 1'b1;
    addr = a;
    bits = b;
    @(negedge clk);
    wv = 1'b0;
  endtask
  // Rail timing has a tick of slack plus sync delay, so the edge must land between n-2 and n+8 clocks
  task automatic wait_rail(input int b, input logic v, input int n);
    int i = 0;
    while (i < n + 8 && rails[b] !== v) begin
      step(1);
      i++;
    end
    check_bit(rails[b], v);
    check_bit(1'(i >= n - 2), 1'b1);
  endtask
  task automatic t_reset;
    check_vec({8'h00, sc}, 12'h000);
    check_bit(seven_in, 1'b0);
    check_vec(sp.step_down_three_mv, SD3_ALT);
  endtask
  task automatic t_i2c;
    wr(rail_seq_pkg::I2C_READ_BYTE, 4'hF);
    check_vec({8'h00, sc}, 12'h000);
    wr(rail_seq_pkg::I2C_WRITE_BYTE, 4'hA);
    check_vec({8'h00, sc}, 12'h00A);
    step(1);
    check_bit(dsr, 1'b1);
    wr(rail_seq_pkg::I2C_WRITE_BYTE, 4'h5);
    check_vec({8'h00, sc}, 12'h005);
    step(1);
    check_bit(dsr, 1'b0);
  endtask
  // Set and clear together: the new event must win
  task automatic t_irq;
    ev = 1'b1;
    evc = 1'b1;
    step(1);
    ev = 1'b0;
    step(1);
    check_bit(five_in, 1'b0);
    step(1);
    evc = 1'b0;
    check_bit(five_in, 1'b1);
    ev = 1'b1;
    step(1);
    ev = 1'b0;
    step(5);
    check_bit(five_in, 1'b0);
    evc = 1'b1;
    step(1);
    evc = 1'b0;
    step(2);
    check_bit(five_in, 1'b1);
  endtask
  // A short pulse first must not bring the first rail up early
  task automatic t_seq;
    four = 1'b1;
    step(rail_seq_pkg::EXT_GOOD_DELAY_US * TK / 2);
    four = 1'b0;
    step(100);
    check_bit(rails.step_down_one, 1'b0);
    four = 1'b1;
    wait_rail(4, 1'b1, rail_seq_pkg::EXT_GOOD_DELAY_US * TK);
    check_bit(rails.linear_reg_one, 1'b0);
    // Power good alone must not release reset while step_down_two is off
    good = 1'b1;
    two = 1'b0;
    wait_rail(3, 1'b1, rail_seq_pkg::CHAIN_DELAY_US * TK);
    check_bit(seven_in, 1'b0);
    wait_rail(2, 1'b1, rail_seq_pkg::CHAIN_DELAY_US * TK);
    // Select taken at power-on; a later change must be ignored
    two = 1'b1;
    wait_rail(1, 1'b1, rail_seq_pkg::CHAIN_DELAY_US * TK);
    check_vec(sp.step_down_three_mv, rail_seq_pkg::IMG2_SD3_PRI_MV);
    wait_rail(0, 1'b1, (rail_seq_pkg::LAST_DELAY_US - rail_seq_pkg::CHAIN_DELAY_US) * TK);
    check_vec(sp.step_down_two_mv, rail_seq_pkg::IMG2_SD2_MV);
    check_vec(sp.step_down_one_mv, rail_seq_pkg::IMG2_SD1_MV);
    step(RST_US * TK - 4);
    check_bit(seven_in, 1'b0);
    step(8);
    check_bit(seven_in, 1'b1);
    four = 1'b0;
    wait_rail(1, 1'b0, 4);
    wait_rail(4, 1'b0, rail_seq_pkg::OFF_DELAY_US * TK);
    check_vec({7'h00, rails}, 12'h000);
    step(2);
    check_bit(seven_in, 1'b0);
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    step(6);
    resetn = 1'b1;
    step(6);
    t_reset();
    t_i2c();
    t_irq();
    t_seq();
    test_done();
  end
  initial begin
    #1000000;
    failures++;
    test_done();
  end
endmodule
`default_nettype wire

// [verif/rail_seq_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
// Checks the second image's pin behaviour; the bench builds only that image
module rail_seq_monitor #(
  parameter logic [1:0] CONFIG_IMAGE = rail_seq_pkg::IMG_FIRST
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic i2c_write_valid,
  input wire logic [7:0] i2c_addr_byte,
  input wire logic [3:0] i2c_sleep_bits,
  input wire logic event_in,
  input wire logic event_clear,
  input wire logic io_line_five_out,
  input wire logic io_line_five_oe,
  input wire logic io_line_seven_out,
  input wire logic io_line_seven_oe,
  input wire rail_seq_pkg::rails_s rail_enable,
  input wire rail_seq_pkg::setpoints_s setpoints,
  input wire rail_seq_pkg::sleep_ctl_s sleep_ctl,
  input wire logic deep_sleep_req
);
  // Pin roles differ per image; image-two checks stay quiet in image one
  localparam bit IMG2 = (CONFIG_IMAGE == rail_seq_pkg::IMG_SECOND);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Refuse and deep-sleep checks guard with past reset so values frozen during reset never count
  AST_ADDR_WRITE: assert property (i2c_write_valid && i2c_addr_byte == rail_seq_pkg::I2C_WRITE_BYTE
    |=> sleep_ctl == $past(i2c_sleep_bits)) else $error("write to own address not taken");
  AST_ADDR_REFUSE: assert property ($past(resetn) && !(i2c_write_valid && i2c_addr_byte == 8'h4A)
    |=> $stable(sleep_ctl)) else $error("sleep bits changed without a write");
  AST_DEEP_REQ: assert property (IMG2 && $past(resetn) |-> deep_sleep_req == $past(sleep_ctl.deep_sleep_en))
    else $error("deep sleep request not from register bit");
  // Pending flag then pin register: the pin follows two clocks after the event
  AST_IRQ_SET: assert property (IMG2 && event_in |-> ##2 io_line_five_oe)
    else $error("event did not pull irq low");
  AST_IRQ_CLR: assert property (IMG2 && event_clear && !event_in |-> ##2 !io_line_five_oe)
    else $error("irq not released on clear");
  AST_OD_LOW: assert property (!io_line_five_out && !io_line_seven_out)
    else $error("open drain output drives high");
  AST_RST_HOLD: assert property (IMG2 && $past(resetn) && !$past(rail_enable.step_down_two) && !rail_enable.step_down_two
    |-> io_line_seven_oe) else $error("reset released before rail up");
  AST_CHAIN: assert property ($rose(rail_enable.linear_reg_one) |-> rail_enable.step_down_one)
    else $error("rail started out of order");
  AST_SD3_HOLD: assert property (rail_enable.step_down_three && $past(rail_enable.step_down_three, 2)
    |-> $stable(setpoints.step_down_three_mv)) else $error("setpoint moved while rail on");
endmodule
bind pmic_gpio_rail_sequencer rail_seq_monitor #(.CONFIG_IMAGE(CONFIG_IMAGE)) u_mon (.clk, .resetn,
  .i2c_write_valid, .i2c_addr_byte, .i2c_sleep_bits, .event_in, .event_clear, .io_line_five_out,
  .io_line_five_oe, .io_line_seven_out, .io_line_seven_oe, .rail_enable, .setpoints, .sleep_ctl, .deep_sleep_req);
`default_nettype wire
